// *** shared/saar_pkg.sv ***
`default_nettype none
package saar_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W          = 12;
  localparam logic [11:0] ENABLE_ACK_OFS  = 12'h024;
  localparam logic [11:0] ATTR_CTRL_OFS   = 12'h028;

  // ----------------------------------------------------------------
  // Field layout of memory_attr_control
  // ----------------------------------------------------------------
  localparam int unsigned ATTR_W          = 12;
  localparam int unsigned STRUCT_SH_LSB   = 10;
  localparam int unsigned STRUCT_OC_LSB   = 8;
  localparam int unsigned STRUCT_IC_LSB   = 6;
  localparam int unsigned RING_SH_LSB     = 4;
  localparam int unsigned RING_OC_LSB     = 2;
  localparam int unsigned RING_IC_LSB     = 0;
  localparam int unsigned GROUP_LSB_HI    = 6;

  // ----------------------------------------------------------------
  // Field layout of enable_ack_status
  // ----------------------------------------------------------------
  localparam int unsigned EN_W            = 4;
  localparam int unsigned EN_TRANSLATE    = 0;
  localparam int unsigned EN_PAGE_REQ     = 1;
  localparam int unsigned EN_EVENT        = 2;
  localparam int unsigned EN_COMMAND      = 3;

  // ----------------------------------------------------------------
  // Attribute encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SAAR_SH_NON   = 2'h0,
    SAAR_SH_RSVD  = 2'h1,
    SAAR_SH_OUTER = 2'h2,
    SAAR_SH_INNER = 2'h3
  } saar_share_t;

  typedef enum logic [1:0] {
    SAAR_CA_NONE  = 2'h0,
    SAAR_CA_WB    = 2'h1,
    SAAR_CA_WT    = 2'h2,
    SAAR_CA_RSVD  = 2'h3
  } saar_cache_t;

  // Raw field group as stored, and decoded attribute as applied.
  typedef struct packed {
    logic [1:0] share;
    logic [1:0] outer;
    logic [1:0] inner;
  } saar_group_t;

  typedef struct packed {
    saar_share_t share;
    saar_cache_t outer;
    saar_cache_t inner;
  } saar_attr_t;

  localparam logic [5:0]  GROUP_RST_VAL   = 6'h00;
  localparam logic [3:0]  CACHE_SUPPORTED = 4'h7;
  localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

endpackage
`default_nettype wire

// *** hdl/saar_attr_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
module saar_attr_regs
  import saar_pkg::*;
#(
  parameter int unsigned NUM_ENH_RINGS   = 2,
  parameter bit          STRUCT_PRESET   = 1'b0,
  parameter logic [5:0]  STRUCT_PRESET_V = 6'h15,
  parameter bit          RING_PRESET     = 1'b0,
  parameter logic [5:0]  RING_PRESET_V   = 6'h15,
  parameter logic [3:0]  CACHE_SUPPORT   = CACHE_SUPPORTED
) (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     sys_rst,
  // Register port
  input  wire logic                     reg_req,
  input  wire logic                     reg_wr,
  input  wire logic [ADDR_W-1:0]        reg_addr,
  input  wire logic [31:0]              reg_wdata,
  output logic                          reg_ack,
  output logic [31:0]                   reg_rdata,
  // Enables from main_enable_control and completion pulses from the datapath
  input  wire logic [EN_W-1:0]          main_enable,
  input  wire logic [EN_W-1:0]          enable_settled,
  input  wire logic [NUM_ENH_RINGS-1:0] enhanced_cmd_ring_enable,
  input  wire logic [NUM_ENH_RINGS-1:0] enhanced_cmd_ring_enable_ack,
  // Allocation hints held in the base registers
  input  wire logic [1:0]               stream_table_base_hint,
  input  wire logic [1:0]               command_ring_hint,
  input  wire logic [1:0]               event_ring_hint,
  input  wire logic [1:0]               page_request_ring_hint,
  // Access requests for memory type checking
  input  wire logic                     stream_entry_fetch_req,
  input  wire logic                     ring_access_req,
  // Effective attributes, acknowledgement status and access faults
  output saar_attr_t                    structure_fetch_attr,
  output saar_attr_t                    ring_access_attr,
  output logic [1:0]                    stream_table_hint_eff,
  output logic [1:0]                    command_ring_hint_eff,
  output logic [1:0]                    event_ring_hint_eff,
  output logic [1:0]                    page_request_ring_hint_eff,
  output logic [EN_W-1:0]               enable_ack_status,
  output logic                          stream_entry_fetch_fault,
  output logic                          ring_access_abort
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic saar_cache_t dec_cache(input logic [1:0] code);
    dec_cache = (code == SAAR_CA_RSVD) ? SAAR_CA_NONE : saar_cache_t'(code);
  endfunction

  function automatic saar_attr_t dec_group(input saar_group_t g);
    saar_attr_t a;
    a.outer = dec_cache(g.outer);
    a.inner = dec_cache(g.inner);
    if (g.outer == SAAR_CA_NONE && g.inner == SAAR_CA_NONE) begin
      a.share = SAAR_SH_OUTER;
    end else if (g.share == SAAR_SH_RSVD) begin
      a.share = SAAR_SH_NON;
    end else begin
      a.share = saar_share_t'(g.share);
    end
    dec_group = a;
  endfunction

  function automatic logic is_cacheable(input saar_attr_t a);
    is_cacheable = (a.outer != SAAR_CA_NONE) || (a.inner != SAAR_CA_NONE);
  endfunction

  function automatic logic is_supported(input saar_attr_t a);
    is_supported = CACHE_SUPPORT[a.outer] && CACHE_SUPPORT[a.inner];
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  saar_group_t     struct_grp_reg;
  saar_group_t     struct_grp_next;
  saar_group_t     ring_grp_reg;
  saar_group_t     ring_grp_next;
  logic [EN_W-1:0] ack_reg;
  logic [EN_W-1:0] ack_next;

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  wire logic hit_ack   = reg_addr == ENABLE_ACK_OFS;
  wire logic hit_attr  = reg_addr == ATTR_CTRL_OFS;
  wire logic attr_wr   = reg_req && reg_wr && hit_attr;

  // Guards look at both the request and its acknowledgement, so a write
  // landing while an enable is still settling is refused as well.
  wire logic struct_open = !main_enable[EN_TRANSLATE] && !ack_reg[EN_TRANSLATE];
  wire logic ring_open   = !main_enable[EN_COMMAND] && !ack_reg[EN_COMMAND]
                        && !main_enable[EN_EVENT] && !ack_reg[EN_EVENT]
                        && !main_enable[EN_PAGE_REQ] && !ack_reg[EN_PAGE_REQ]
                        && !(|enhanced_cmd_ring_enable)
                        && !(|enhanced_cmd_ring_enable_ack);

  // Preset groups ignore writes entirely, so readback always equals the
  // fixed value in use and the effective attribute cannot move.
  wire logic struct_wr_ok = attr_wr && struct_open && !STRUCT_PRESET;
  wire logic ring_wr_ok   = attr_wr && ring_open && !RING_PRESET;

  wire saar_group_t wr_struct = reg_wdata[STRUCT_IC_LSB +: GROUP_LSB_HI];
  wire saar_group_t wr_ring   = reg_wdata[RING_IC_LSB +: GROUP_LSB_HI];

  assign struct_grp_next = struct_wr_ok ? wr_struct : struct_grp_reg;
  assign ring_grp_next   = ring_wr_ok ? wr_ring : ring_grp_reg;

  // Only ack bits whose change has completed take the new enable value.
  assign ack_next = (ack_reg & ~enable_settled) | (main_enable & enable_settled);

  wire logic [31:0] rd_attr = {{(32-ATTR_W){1'b0}}, struct_grp_reg, ring_grp_reg};
  wire logic [31:0] rd_ack  = {{(32-EN_W){1'b0}}, ack_reg};
  wire logic [31:0] rd_mux  = hit_attr ? rd_attr : (hit_ack ? rd_ack : READ_ZERO);

  // ----------------------------------------------------------------
  // Effective attributes
  // ----------------------------------------------------------------
  wire saar_attr_t struct_eff = dec_group(struct_grp_reg);
  wire saar_attr_t ring_eff   = dec_group(ring_grp_reg);
  wire logic       struct_ca  = is_cacheable(struct_eff);
  wire logic       ring_ca    = is_cacheable(ring_eff);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Without a preset the fields power up undefined in principle; zero is
  // used so that simulation stays free of unknowns.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      struct_grp_reg <= STRUCT_PRESET ? STRUCT_PRESET_V : GROUP_RST_VAL;
      ring_grp_reg   <= RING_PRESET ? RING_PRESET_V : GROUP_RST_VAL;
      ack_reg        <= '0;
    end else begin
      struct_grp_reg <= struct_grp_next;
      ring_grp_reg   <= ring_grp_next;
      ack_reg        <= ack_next;
    end
  end

  // Writes to the acknowledgement offset fall through here untouched.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_ack   <= 1'b0;
      reg_rdata <= READ_ZERO;
    end else begin
      reg_ack   <= reg_req;
      reg_rdata <= (reg_req && !reg_wr) ? rd_mux : READ_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      structure_fetch_attr       <= '0;
      ring_access_attr           <= '0;
      stream_table_hint_eff      <= '0;
      command_ring_hint_eff      <= '0;
      event_ring_hint_eff        <= '0;
      page_request_ring_hint_eff <= '0;
      enable_ack_status          <= '0;
      stream_entry_fetch_fault   <= 1'b0;
      ring_access_abort          <= 1'b0;
    end else begin
      structure_fetch_attr       <= struct_eff;
      ring_access_attr           <= ring_eff;
      stream_table_hint_eff      <= struct_ca ? stream_table_base_hint : 2'h0;
      command_ring_hint_eff      <= ring_ca ? command_ring_hint : 2'h0;
      event_ring_hint_eff        <= ring_ca ? event_ring_hint : 2'h0;
      page_request_ring_hint_eff <= ring_ca ? page_request_ring_hint : 2'h0;
      enable_ack_status          <= ack_next;
      stream_entry_fetch_fault   <= stream_entry_fetch_req && !is_supported(struct_eff);
      ring_access_abort          <= ring_access_req && !is_supported(ring_eff);
    end
  end

endmodule
`default_nettype wire

// *** sim/saar_attr_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module saar_attr_checker
  import saar_pkg::*;
#(
  parameter int unsigned NUM_ENH_RINGS = 2
) (
  // Clock and reset
  input wire logic             core_clk,
  input wire logic             sys_rst,
  // Register port
  input wire logic             reg_req,
  input wire logic             reg_wr,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0]      reg_wdata,
  input wire logic             reg_ack,
  input wire logic [31:0]      reg_rdata,
  // Enables and attributes
  input wire logic [EN_W-1:0]  main_enable,
  input wire logic [EN_W-1:0]  enable_settled,
  input wire logic [NUM_ENH_RINGS-1:0] enhanced_cmd_ring_enable,
  input wire logic [NUM_ENH_RINGS-1:0] enhanced_cmd_ring_enable_ack,
  input wire logic [EN_W-1:0]  enable_ack_status,
  input wire saar_attr_t       structure_fetch_attr,
  input wire saar_attr_t       ring_access_attr,
  input wire logic             stream_entry_fetch_req,
  input wire logic             stream_entry_fetch_fault
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  ack_read_zero_a: assert property (reg_ack && $past(reg_addr) == ENABLE_ACK_OFS
    |-> reg_rdata[31:EN_W] == 28'h0) else $error("ack status upper bits not zero");
  attr_upper_zero_a: assert property (reg_ack && $past(reg_addr) == ATTR_CTRL_OFS
    |-> reg_rdata[31:12] == 20'h0) else $error("attribute upper bits not zero");
  ack_follow_a: assert property (!$past(sys_rst) |-> enable_ack_status ==
    (($past(enable_settled) & $past(main_enable)) |
     (~$past(enable_settled) & $past(enable_ack_status)))) else $error("ack bit moved alone");
  // The forcing looks at the raw cache codes, so it is checked from the accepted write.
  struct_outer_a: assert property (reg_req && reg_wr && reg_addr == ATTR_CTRL_OFS
    && reg_wdata[STRUCT_IC_LSB +: 4] == 4'h0 && !main_enable[EN_TRANSLATE]
    && !enable_ack_status[EN_TRANSLATE]
    |-> ##2 structure_fetch_attr.share == SAAR_SH_OUTER) else $error("structure share not outer");
  ring_outer_a: assert property (reg_req && reg_wr && reg_addr == ATTR_CTRL_OFS
    && reg_wdata[RING_IC_LSB +: 4] == 4'h0 && main_enable[3:1] == 3'h0
    && enable_ack_status[3:1] == 3'h0 && !(|enhanced_cmd_ring_enable)
    && !(|enhanced_cmd_ring_enable_ack)
    |-> ##2 ring_access_attr.share == SAAR_SH_OUTER) else $error("ring share not outer");
  no_reserved_a: assert property (!$past(sys_rst) |->
    structure_fetch_attr.share != SAAR_SH_RSVD && structure_fetch_attr.outer != SAAR_CA_RSVD
    && structure_fetch_attr.inner != SAAR_CA_RSVD) else $error("reserved code applied");
  fetch_fault_a: assert property (stream_entry_fetch_fault |->
    $past(stream_entry_fetch_req)) else $error("fetch fault without request");
  struct_guard_a: assert property (reg_req && reg_wr && reg_addr == ATTR_CTRL_OFS &&
    (main_enable[EN_TRANSLATE] || enable_ack_status[EN_TRANSLATE])
    |=> ##1 $stable(structure_fetch_attr)) else $error("guarded structure write applied");
endmodule
bind saar_attr_regs saar_attr_checker #(.NUM_ENH_RINGS(NUM_ENH_RINGS)) chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .reg_wdata(reg_wdata),
  .enhanced_cmd_ring_enable(enhanced_cmd_ring_enable),
  .enhanced_cmd_ring_enable_ack(enhanced_cmd_ring_enable_ack),
  .reg_req(reg_req), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_ack(reg_ack),
  .reg_rdata(reg_rdata), .main_enable(main_enable), .enable_settled(enable_settled),
  .enable_ack_status(enable_ack_status), .structure_fetch_attr(structure_fetch_attr),
  .ring_access_attr(ring_access_attr), .stream_entry_fetch_req(stream_entry_fetch_req),
  .stream_entry_fetch_fault(stream_entry_fetch_fault));
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import saar_pkg::*;
;
  logic        core_clk = 0, sys_rst = 1, reg_req = 0, reg_wr = 0, reg_ack, st_req = 0;
  logic        rg_req = 0, st_flt, rg_abt;
  logic [11:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, rd;
  logic [3:0]  men = 0, settle = 0, ack_st;
  logic [1:0]  enh_en = 0, enh_ack = 0, st_heff, cmd_heff, ev_heff, pr_heff;
  logic [5:0]  g, e;
  saar_attr_t  s_attr, r_attr;
  int          failures = 0, cmp_count = 0;

  always #20 core_clk = ~core_clk;

  // A narrowed support mask makes write-through fetches fault.
  saar_attr_regs #(.CACHE_SUPPORT(4'h3)) DUT (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_req(reg_req), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_ack(reg_ack), .reg_rdata(reg_rdata), .main_enable(men), .enable_settled(settle),
    .enhanced_cmd_ring_enable(enh_en), .enhanced_cmd_ring_enable_ack(enh_ack),
    .stream_table_base_hint(2'h3), .command_ring_hint(2'h2), .event_ring_hint(2'h1),
    .page_request_ring_hint(2'h3), .stream_entry_fetch_req(st_req),
    .ring_access_req(rg_req), .structure_fetch_attr(s_attr), .ring_access_attr(r_attr),
    .stream_table_hint_eff(st_heff), .command_ring_hint_eff(cmd_heff),
    .event_ring_hint_eff(ev_heff), .page_request_ring_hint_eff(pr_heff),
    .enable_ack_status(ack_st),
    .stream_entry_fetch_fault(st_flt), .ring_access_abort(rg_abt));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    #1;
    reg_req = 1;
    reg_wr = wr;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk);
    #1;
    reg_req = 0;
    check({31'h0, reg_ack}, 32'h1);
    rd = reg_rdata;
  endtask

  task automatic wr_rd(input logic [11:0] a, input logic [31:0] d);
    acc(1, a, d);
    acc(0, a, 32'h0);
  endtask

  task automatic pulse_settle;
    settle = 4'hf;
    @(posedge core_clk);
    #1;
    settle = 4'h0;
  endtask

  function automatic logic [5:0] dec(input logic [5:0] v);
    logic [1:0] sh, oc, ic;
    sh = (v[5:4] == 2'h1) ? 2'h0 : v[5:4];
    oc = (v[3:2] == 2'h3) ? 2'h0 : v[3:2];
    ic = (v[1:0] == 2'h3) ? 2'h0 : v[1:0];
    if (v[3:0] == 4'h0) sh = 2'h2;
    return {sh, oc, ic};
  endfunction

  task automatic stop_test;
    $display("Compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #400000;
    failures++;
    stop_test;
  end

  initial begin
    repeat (20) @(posedge core_clk);
    #1 sys_rst = 0;
    acc(0, ATTR_CTRL_OFS, 32'h0);
    check(rd, 32'h0);
    check({26'h0, s_attr}, 32'h20);
    for (int v = 0; v < 64; v++) begin
      g = v[5:0];
      e = dec(g);
      acc(1, ATTR_CTRL_OFS, {20'hfffff, g, g});
      acc(0, ATTR_CTRL_OFS, 32'h0);
      check(rd, {20'h0, g, g});
      check({26'h0, s_attr}, {26'h0, e});
      check({26'h0, r_attr}, {26'h0, e});
      check({30'h0, st_heff}, (e[3:0] != 0) ? 32'h3 : 32'h0);
      check({30'h0, cmd_heff}, (e[3:0] != 0) ? 32'h2 : 32'h0);
      check({30'h0, ev_heff}, (e[3:0] != 0) ? 32'h1 : 32'h0);
      check({30'h0, pr_heff}, (e[3:0] != 0) ? 32'h3 : 32'h0);
      st_req = 1;
      rg_req = 1;
      @(posedge core_clk);
      #1;
      st_req = 0;
      rg_req = 0;
      check({31'h0, st_flt}, {31'h0, e[3:2] == 2'h2 || e[1:0] == 2'h2});
      check({31'h0, rg_abt}, {31'h0, e[3:2] == 2'h2 || e[1:0] == 2'h2});
    end
    men = 4'h1;
    wr_rd(ATTR_CTRL_OFS, 32'h0);
    check(rd, 32'hfc0);
    pulse_settle;
    check({28'h0, ack_st}, 32'h1);
    men = 4'h0;
    acc(0, ENABLE_ACK_OFS, 32'h0);
    check(rd, 32'h1);
    wr_rd(ATTR_CTRL_OFS, 32'h0);
    check(rd, 32'hfc0);
    wr_rd(ENABLE_ACK_OFS, 32'hffffffff);
    check(rd, 32'h1);
    pulse_settle;
    check({28'h0, ack_st}, 32'h0);
    wr_rd(ATTR_CTRL_OFS, 32'h0);
    check(rd, 32'h0);
    for (int i = 0; i < 7; i++) begin
      {enh_ack, enh_en, men[3:1]} = 7'h1 << i;
      wr_rd(ATTR_CTRL_OFS, 32'h3f);
      check(rd, 32'h0);
    end
    {enh_ack, enh_en, men} = 8'h0;
    wr_rd(ATTR_CTRL_OFS, 32'h3f);
    check(rd, 32'h3f);
    acc(0, 12'h030, 32'h0);
    check(rd, 32'h0);
    stop_test;
  end
endmodule
`default_nettype wire
